// ===== sim/llc_reg_bank_assertions.sv
// Concurrent checks on the ports of the link control register bank.
`default_nettype none
module llc_chk (
	input wire core_clk,
	input wire rst_n,
	input wire serial_tx_data,
	input wire tx_bit_strobe,
	input wire rx_bit_ff,
	input wire rx_bit_valid_ff,
	input wire packet_received_evt,
	input wire transmit_block_ack_evt,
	input wire error_evt,
	input wire remote_setup_rcvd,
	input wire interrupt_request_n_ff,
	input wire data_oe_ff,
	input wire loopback_ff,
	input wire dma_enable_ff,
	input wire send_disc_ff,
	input wire send_sabm_ff,
	input wire send_ack_ff,
	input wire link_up_ff
);
	wire evt;
	assign evt = packet_received_evt | transmit_block_ack_evt | error_evt;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	irq_on_event_a: assert property (evt |=> !interrupt_request_n_ff)
		else $error("interrupt missed an event");
	irq_fall_cause_a: assert property ($fell(interrupt_request_n_ff) |-> $past(evt))
		else $error("interrupt fell without an event");
	irq_clear_read_a: assert property ($rose(interrupt_request_n_ff) |-> data_oe_ff)
		else $error("interrupt rose without a read");
	loop_path_a: assert property (loopback_ff && $past(loopback_ff) && $past(loopback_ff, 2)
		|-> rx_bit_valid_ff == $past(tx_bit_strobe)
		&& (!rx_bit_valid_ff || rx_bit_ff == $past(serial_tx_data)))
		else $error("loopback path wrong");
	link_down_a: assert property (!dma_enable_ff [*3] |-> !link_up_ff)
		else $error("link up while disconnected");
	ack_cause_a: assert property (send_ack_ff |-> $past(remote_setup_rcvd, 2))
		else $error("reply without remote set-up");
	disc_first_a: assert property (send_disc_ff |=> !send_sabm_ff [*2])
		else $error("set-mode before acknowledge");
	sabm_pulse_a: assert property (send_sabm_ff |=> !send_sabm_ff)
		else $error("set-mode pulse too long");
endmodule // llc_chk

bind llc_reg_bank llc_chk llc_chk_inst (.core_clk, .rst_n, .serial_tx_data, .tx_bit_strobe,
	.rx_bit_ff, .rx_bit_valid_ff, .packet_received_evt, .transmit_block_ack_evt, .error_evt,
	.remote_setup_rcvd, .interrupt_request_n_ff, .data_oe_ff, .loopback_ff, .dma_enable_ff,
	.send_disc_ff, .send_sabm_ff, .send_ack_ff, .link_up_ff);
`default_nettype wire

// ===== sim/llc_remote_station.sv
// Behavioural remote station: acknowledges commands and clocks receive frames.
`default_nettype none
module llc_remote_station (
	input wire logic core_clk,
	input wire logic send_disc_ff,
	input wire logic send_sabm_ff,
	input wire logic slow,
	input wire logic frame_on,
	output logic ack_rcvd,
	output logic serial_rx_clock,
	output logic serial_rx_data
);
	timeunit 1ns;
	timeprecision 100ps;
	initial ack_rcvd = 1'b0;
	always @(posedge core_clk) begin
		if (send_disc_ff || send_sabm_ff) begin
			repeat (slow ? 20 : 1) @(negedge core_clk);
			ack_rcvd = 1'b1;
			@(negedge core_clk);
			ack_rcvd = 1'b0;
		end
	end
	// The link clock stands still between frames while the data line keeps toggling.
	initial begin
		serial_rx_clock = 1'b0;
		serial_rx_data = 1'b0;
		#3.3;
		forever begin
			#62.5;
			serial_rx_clock = frame_on & ~serial_rx_clock;
			if (!serial_rx_clock)
				serial_rx_data = frame_on ? 1'($urandom) : ~serial_rx_data;
		end
	end
endmodule // llc_remote_station
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the link control register bank.
`default_nettype none
`include "llc_link_defines.vh"
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk, rst_n, cs_n, we_n, re_n, tx_d, tx_s, pe, xe, ee, rs, slow, fr, rt, ir, ri;
	logic [3:0] ia, a;
	logic [7:0] din, sq, ef, rd, d, main_w, aux_w;
	logic [2:0] ne, flags;
	wire oe, rxb, rxv, irq, rbr, rst_t, lp, hd, dma, sd, ss, sa, lu, ack, rck, rdt;
	wire [7:0] dout, aux;
	int errors = 0, n_compared = 0, n_disc = 0, n_sabm = 0, n_ack = 0, n_val = 0, m;
	llc_reg_bank llc_reg_bank_inst (.core_clk, .rst_n, .cs_n, .we_n, .re_n, .ia,
		.data_in(din), .data_out_ff(dout), .data_oe_ff(oe), .serial_rx_data(rdt),
		.serial_rx_clock(rck), .serial_tx_data(tx_d), .tx_bit_strobe(tx_s), .rx_bit_ff(rxb),
		.rx_bit_valid_ff(rxv), .packet_received_evt(pe), .transmit_block_ack_evt(xe),
		.error_evt(ee), .next_expected_seq(ne), .seq_status_in(sq), .retry_timer_expired(rt),
		.idle_rts_status(ir), .rec_idle(ri), .error_flags_in(ef), .remote_setup_rcvd(rs),
		.ack_rcvd(ack), .link_lost(1'b0), .interrupt_request_n_ff(irq),
		.receive_buffer_ready_ff(rbr), .register_self_test_ff(rst_t), .loopback_ff(lp),
		.half_duplex_ff(hd), .dma_enable_ff(dma), .link_control_aux_ff(aux),
		.send_disc_ff(sd), .send_sabm_ff(ss), .send_ack_ff(sa), .link_up_ff(lu));
	llc_remote_station llc_remote_station_inst (.core_clk, .send_disc_ff(sd),
		.send_sabm_ff(ss), .slow, .frame_on(fr), .ack_rcvd(ack), .serial_rx_clock(rck),
		.serial_rx_data(rdt));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		n_disc += sd;
		n_sabm += ss;
		n_ack += sa;
		n_val += rxv;
	end
	function automatic logic [7:0] exp_reg(input logic [3:0] x);
		case (x)
			4'h0: return main_w & `LLC_MAIN_WMASK;
			4'h1: return aux_w & `LLC_AUX_WMASK;
			4'h2: return sq;
			4'h3: return {flags, 1'b0, ne, 1'b0};
			4'h4: return {rt, ir, ri, 5'h00};
			4'h5: return ef;
			default: return 8'h00;
		endcase
	endfunction
	function automatic logic [7:0] exp_modes();
		return {3'h0, ~main_w[0], main_w[5], main_w[3], main_w[2], main_w[1]};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic wr, input logic [3:0] x, input logic [7:0] v);
		@(negedge core_clk);
		cs_n = 1'b0;
		we_n = ~wr;
		re_n = wr;
		ia = x;
		din = v;
		repeat (4) @(negedge core_clk);
		rd = dout;
		cs_n = 1'b1;
		we_n = 1'b1;
		re_n = 1'b1;
		repeat (5) @(negedge core_clk);
	endtask
	task automatic wait_link(input int n);
		for (int w = 0; w < n && lu !== 1'b1; w++)
			@(negedge core_clk);
	endtask
	task automatic report_and_stop;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#300us;
		errors++;
		report_and_stop;
	end
	initial begin
		{cs_n, we_n, re_n, tx_d, tx_s, pe, xe, ee, rs, slow, fr, rt, ir, ri} = 14'h3800;
		{ia, din, sq, ef, ne, flags} = '0;
		main_w = `LLC_MAIN_RESET;
		aux_w = `LLC_AUX_RESET;
		rst_n = 1'b0;
		void'($urandom(75583));
		repeat (10) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge core_clk);
		for (int i = 0; i < 32; i++) begin
			a = i[3:0];
			{sq, ef, ne, rt, ir, ri} = 22'($urandom);
			acc(1'b0, a, 8'h00);
			chk(rd, exp_reg(a));
			d = 8'($urandom);
			d[0] = d[0] | (a == 4'h0);
			d[3] = d[3] & (a != 4'h0);
			acc(1'b1, a, d);
			main_w = (a == 4'h0) ? d : main_w;
			aux_w = (a == 4'h1) ? d : aux_w;
			acc(1'b0, a, 8'h00);
			chk(rd, exp_reg(a));
			chk({3'h0, dma, hd, lp, rst_t, rbr}, exp_modes());
			chk(aux, aux_w & `LLC_AUX_WMASK);
		end
		$display("register test done");
		for (int k = 0; k < 3; k++) begin
			@(negedge core_clk);
			{pe, xe, ee} = 3'h4 >> k;
			flags = 3'h4 >> k;
			@(negedge core_clk);
			{pe, xe, ee} = 3'h0;
			chk({7'h00, irq}, 8'h00);
			acc(1'b0, 4'h3, 8'h00);
			chk(rd, exp_reg(4'h3));
			flags = 3'h0;
			chk({7'h00, irq}, 8'h01);
		end
		$display("interrupt test done");
		acc(1'b1, 4'hE, 8'h5a);
		acc(1'b1, 4'hF, 8'h5a);
		main_w = 8'h09;
		acc(1'b1, 4'h0, main_w);
		chk({7'h00, lp}, 8'h01);
		fr = 1'b1;
		m = n_val;
		for (int k = 0; k < 40; k++) begin
			{tx_d, tx_s} = 2'($urandom);
			m += tx_s;
			@(negedge core_clk);
		end
		{tx_d, tx_s} = 2'b00;
		@(negedge core_clk);
		chk(8'(n_val), 8'(m));
		main_w = 8'h01;
		acc(1'b1, 4'h0, main_w);
		repeat (40) @(negedge core_clk);
		fr = 1'b0;
		chk({7'h00, n_val > m}, 8'h01);
		$display("loopback test done");
		for (int s = 0; s < 2; s++) begin
			slow = s[0];
			m = n_disc;
			acc(1'b1, 4'h0, 8'h90);
			wait_link(200);
			chk({7'h00, lu}, 8'h01);
			chk(8'(n_disc - m), 8'h01);
			acc(1'b1, 4'h0, 8'h01);
			chk({7'h00, lu}, 8'h00);
			m = n_sabm;
			acc(1'b1, 4'h0, 8'h10);
			wait_link(200);
			chk({7'h00, lu}, 8'h01);
			chk(8'(n_sabm - m), 8'h01);
			acc(1'b1, 4'h0, 8'h01);
		end
		$display("active set-up test done");
		m = n_disc + n_sabm;
		acc(1'b1, 4'h0, 8'h00);
		repeat (50) @(negedge core_clk);
		chk(8'(n_disc + n_sabm - m), 8'h00);
		chk({7'h00, lu}, 8'h00);
		rs = 1'b1;
		@(negedge core_clk);
		rs = 1'b0;
		wait_link(10);
		chk({7'h00, lu}, 8'h01);
		acc(1'b0, 4'h4, 8'h00);
		chk(rd, exp_reg(4'h4) | 8'h01);
		chk(8'(n_ack), 8'h01);
		$display("passive set-up test done");
		report_and_stop;
	end
endmodule // tb
`default_nettype wire

// ===== verilog/llc_link_defines.vh
// Constants for the link control register bank.
//
// Contract
// - Receive-buffer-ready high allows starting information frame reception; low forbids it.
// - Register self-test bit set enters register test; cleared returns normal.
// - Loopback set routes own transmit data back into receive data input.
// - During loopback external receive data and clock pins are ignored.
// - Link-initiate high with manual disconnect low makes device start link set-up.
// - Link-initiate low: device never starts set-up, waits for remote station.
// - Duplex bit 5 low gives full duplex, high gives half duplex.
// - Interrupt output goes low when packet, block-ack or error flag sets.
// - Interrupt output is active low, returns high when event status is read.
// - Status and error registers are read-only; host writes have no effect.
`ifndef LLC_LINK_DEFINES_VH
`define LLC_LINK_DEFINES_VH

// -------------------------------------------------------------------------
// Register indices on the four address lines
// -------------------------------------------------------------------------
`define LLC_ADDR_CTRL_MAIN 4'h0
`define LLC_ADDR_CTRL_AUX 4'h1
`define LLC_ADDR_SEQ_STATUS 4'h2
`define LLC_ADDR_EVENT_STATUS 4'h3
`define LLC_ADDR_LINK_STATE 4'h4
`define LLC_ADDR_ERROR_FLAGS 4'h5

// -------------------------------------------------------------------------
// Main control register fields
// -------------------------------------------------------------------------
`define LLC_MAIN_MANUAL_DISCONNECT_BIT 0
`define LLC_MAIN_RXRDY_BIT 1
`define LLC_MAIN_SELFTEST_BIT 2
`define LLC_MAIN_LOOP_BIT 3
`define LLC_MAIN_INIT_BIT 4
`define LLC_MAIN_HALF_BIT 5
`define LLC_MAIN_DISCONNECT_BEFORE_SETUP_BIT 7
`define LLC_MAIN_WMASK 8'hbf
`define LLC_MAIN_RESET 8'h01

// -------------------------------------------------------------------------
// Auxiliary control register fields
// -------------------------------------------------------------------------
`define LLC_AUX_WMASK 8'hf1
`define LLC_AUX_RESET 8'h00

// -------------------------------------------------------------------------
// Event status register fields
// -------------------------------------------------------------------------
`define LLC_EVT_PKR_BIT 7
`define LLC_EVT_XBA_BIT 6
`define LLC_EVT_ERR_BIT 5
`define LLC_EVT_RESET 3'h0

// -------------------------------------------------------------------------
// Link set-up sequencer states
// -------------------------------------------------------------------------
`define LLC_ST_IDLE 3'h0
`define LLC_ST_SEND_DISC 3'h1
`define LLC_ST_WAIT_DISC 3'h2
`define LLC_ST_SEND_SABM 3'h3
`define LLC_ST_WAIT_SABM 3'h4
`define LLC_ST_UP 3'h5

`endif

// ===== verilog/llc_reg_bank.v
// Control, status and error register bank with loopback and interrupt logic.
`default_nettype none
`include "llc_link_defines.vh"

module llc_reg_bank (
	input wire core_clk,
	input wire rst_n,
	// Host register bus, asynchronous to the core clock.
	input wire cs_n,
	input wire we_n,
	input wire re_n,
	input wire [3:0] ia,
	input wire [7:0] data_in,
	output reg [7:0] data_out_ff,
	output reg data_oe_ff,
	// Serial link pins and the internal transmit bit used by loopback.
	input wire serial_rx_data,
	input wire serial_rx_clock,
	input wire serial_tx_data,
	input wire tx_bit_strobe,
	// Recovered receive bit and its valid strobe.
	output reg rx_bit_ff,
	output reg rx_bit_valid_ff,
	// Events and status levels from the frame logic.
	input wire packet_received_evt,
	input wire transmit_block_ack_evt,
	input wire error_evt,
	input wire [2:0] next_expected_seq,
	input wire [7:0] seq_status_in,
	input wire retry_timer_expired,
	input wire idle_rts_status,
	input wire rec_idle,
	input wire [7:0] error_flags_in,
	// Link set-up events from the frame logic.
	input wire remote_setup_rcvd,
	input wire ack_rcvd,
	input wire link_lost,
	// Interrupt request and mode outputs.
	output reg interrupt_request_n_ff,
	output reg receive_buffer_ready_ff,
	output reg register_self_test_ff,
	output reg loopback_ff,
	output reg half_duplex_ff,
	output reg dma_enable_ff,
	output reg [7:0] link_control_aux_ff,
	// Set-up command strobes and link state.
	output reg send_disc_ff,
	output reg send_sabm_ff,
	output reg send_ack_ff,
	output reg link_up_ff
);

	// -----------------------------------------------------------------
	// Pin synchronisers
	// -----------------------------------------------------------------
	// Host strobes and link pins come from outside the clock domain; only
	// the second stage is read, and strobes reset to their idle level.
	reg [14:0] pin_s1_ff;
	reg [14:0] pin_s2_ff;
	reg [1:0] ext_rx_s1_ff;
	reg [1:0] ext_rx_s2_ff;

	always @(posedge core_clk) begin
		if (!rst_n) begin
			pin_s1_ff <= 15'h7000;
			pin_s2_ff <= 15'h7000;
			ext_rx_s1_ff <= 2'h0;
			ext_rx_s2_ff <= 2'h0;
		end else begin
			pin_s1_ff <= {cs_n, we_n, re_n, ia, data_in};
			pin_s2_ff <= pin_s1_ff;
			ext_rx_s1_ff <= {serial_rx_clock, serial_rx_data};
			ext_rx_s2_ff <= ext_rx_s1_ff;
		end
	end

	// The host strobes are active low on the pins.
	wire cs_s = ~pin_s2_ff[14];
	wire we_s = ~pin_s2_ff[13];
	wire re_s = ~pin_s2_ff[12];
	wire [3:0] ia_s = pin_s2_ff[11:8];
	wire [7:0] din_s = pin_s2_ff[7:0];

	// -----------------------------------------------------------------
	// Host strobe edges
	// -----------------------------------------------------------------
	// A write is committed when the strobe ends, using the index and data
	// captured while it stood; a read begins when the strobe rises.
	reg wr_act_ff;
	reg rd_act_ff;
	reg [3:0] wr_addr_ff;
	reg [7:0] wr_data_ff;

	wire wr_act = cs_s & we_s;
	wire rd_act = cs_s & re_s;
	wire wr_done = wr_act_ff & ~wr_act;
	wire rd_start = rd_act & ~rd_act_ff;

	always @(posedge core_clk) begin
		if (!rst_n) begin
			wr_act_ff <= 1'b0;
			rd_act_ff <= 1'b0;
			wr_addr_ff <= 4'h0;
			wr_data_ff <= 8'h00;
		end else begin
			wr_act_ff <= wr_act;
			rd_act_ff <= rd_act;
			if (wr_act) begin
				wr_addr_ff <= ia_s;
				wr_data_ff <= din_s;
			end
		end
	end

	// -----------------------------------------------------------------
	// Write decode
	// -----------------------------------------------------------------
	// Only the two control registers accept writes; every other index,
	// including the status and error registers, drops the write.
	function [1:0] write_sel;
		input [3:0] addr;
		begin
			case (addr)
			`LLC_ADDR_CTRL_MAIN: write_sel = 2'h1;
			`LLC_ADDR_CTRL_AUX: write_sel = 2'h2;
			default: write_sel = 2'h0;
			endcase
		end
	endfunction

	wire [1:0] wr_sel = write_sel(wr_addr_ff);
	wire wr_main = wr_done & wr_sel[0];
	wire wr_aux = wr_done & wr_sel[1];

	// -----------------------------------------------------------------
	// Control registers
	// -----------------------------------------------------------------
	reg [7:0] link_control_main_ff;

	always @(posedge core_clk) begin
		if (!rst_n) begin
			link_control_main_ff <= `LLC_MAIN_RESET;
			link_control_aux_ff <= `LLC_AUX_RESET;
		end else begin
			if (wr_main) begin
				link_control_main_ff <= wr_data_ff & `LLC_MAIN_WMASK;
			end
			if (wr_aux) begin
				link_control_aux_ff <= wr_data_ff & `LLC_AUX_WMASK;
			end
		end
	end

	// Control fields that steer the set-up sequencer.
	wire manual_disconnect = link_control_main_ff[`LLC_MAIN_MANUAL_DISCONNECT_BIT];
	wire link_initiate = link_control_main_ff[`LLC_MAIN_INIT_BIT];
	wire disconnect_before_setup = link_control_main_ff[`LLC_MAIN_DISCONNECT_BEFORE_SETUP_BIT];

	// -----------------------------------------------------------------
	// Mode outputs
	// -----------------------------------------------------------------
	// The mode outputs follow the control register one cycle later.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			receive_buffer_ready_ff <= 1'b0;
			register_self_test_ff <= 1'b0;
			loopback_ff <= 1'b0;
			half_duplex_ff <= 1'b0;
			dma_enable_ff <= 1'b0;
		end else begin
			receive_buffer_ready_ff <= link_control_main_ff[`LLC_MAIN_RXRDY_BIT];
			register_self_test_ff <= link_control_main_ff[`LLC_MAIN_SELFTEST_BIT];
			loopback_ff <= link_control_main_ff[`LLC_MAIN_LOOP_BIT];
			half_duplex_ff <= link_control_main_ff[`LLC_MAIN_HALF_BIT];
			dma_enable_ff <= ~manual_disconnect;
		end
	end

	// -----------------------------------------------------------------
	// Receive path selection
	// -----------------------------------------------------------------
	// The external clock is sampled, so its rising edge is found two
	// cycles late; in loopback the transmit strobe stands in for it.
	reg ext_clk_d_ff;
	wire ext_rise = ext_rx_s2_ff[1] & ~ext_clk_d_ff;
	wire loop_now = link_control_main_ff[`LLC_MAIN_LOOP_BIT];

	always @(posedge core_clk) begin
		if (!rst_n) begin
			ext_clk_d_ff <= 1'b0;
			rx_bit_ff <= 1'b1;
			rx_bit_valid_ff <= 1'b0;
		end else begin
			ext_clk_d_ff <= ext_rx_s2_ff[1];
			if (loop_now) begin
				rx_bit_ff <= serial_tx_data;
				rx_bit_valid_ff <= tx_bit_strobe;
			end else begin
				rx_bit_valid_ff <= ext_rise;
				if (ext_rise) begin
					rx_bit_ff <= ext_rx_s2_ff[0];
				end
			end
		end
	end

	// -----------------------------------------------------------------
	// Event flags and interrupt
	// -----------------------------------------------------------------
	// A read of the event register clears the flags; an event in the same
	// cycle sets its flag again so it is never lost.
	reg [2:0] evt_flags_ff;
	wire evt_read = rd_start & (ia_s == `LLC_ADDR_EVENT_STATUS);
	wire [2:0] evt_in = {packet_received_evt, transmit_block_ack_evt, error_evt};
	wire [2:0] evt_next = (evt_read ? 3'h0 : evt_flags_ff) | evt_in;
	// The interrupt follows the next flag value, so it falls one cycle after the event.

	always @(posedge core_clk) begin
		if (!rst_n) begin
			evt_flags_ff <= `LLC_EVT_RESET;
			interrupt_request_n_ff <= 1'b1;
		end else begin
			evt_flags_ff <= evt_next;
			interrupt_request_n_ff <= ~(|evt_next);
		end
	end

	// -----------------------------------------------------------------
	// Link set-up sequencer
	// -----------------------------------------------------------------
	// The sequencer strobes pass one more register so that every output
	// of the block comes straight from a flip-flop.
	wire seq_disc;
	wire seq_sabm;
	wire seq_ack;
	wire seq_up;

	llc_setup_seq u_setup (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.manual_disconnect(manual_disconnect),
		.link_initiate(link_initiate),
		.disconnect_before_setup(disconnect_before_setup),
		.remote_setup_rcvd(remote_setup_rcvd),
		.ack_rcvd(ack_rcvd),
		.link_lost(link_lost),
		.send_disc_ff(seq_disc),
		.send_sabm_ff(seq_sabm),
		.send_ack_ff(seq_ack),
		.link_up_ff(seq_up),
		.state_ff()
	);

	always @(posedge core_clk) begin
		if (!rst_n) begin
			send_disc_ff <= 1'b0;
			send_sabm_ff <= 1'b0;
			send_ack_ff <= 1'b0;
			link_up_ff <= 1'b0;
		end else begin
			send_disc_ff <= seq_disc;
			send_sabm_ff <= seq_sabm;
			send_ack_ff <= seq_ack;
			link_up_ff <= seq_up;
		end
	end

	// -----------------------------------------------------------------
	// Read data
	// -----------------------------------------------------------------
	// Unused indices read as zero.
	function [7:0] read_mux;
		input [3:0] addr;
		begin
			case (addr)
			`LLC_ADDR_CTRL_MAIN: read_mux = link_control_main_ff;
			`LLC_ADDR_CTRL_AUX: read_mux = link_control_aux_ff;
			`LLC_ADDR_SEQ_STATUS: read_mux = seq_status_in;
			`LLC_ADDR_EVENT_STATUS: read_mux = {evt_flags_ff, 1'b0, next_expected_seq, 1'b0};
			`LLC_ADDR_LINK_STATE: read_mux = {retry_timer_expired, idle_rts_status, rec_idle,
				4'h0, seq_up};
			`LLC_ADDR_ERROR_FLAGS: read_mux = error_flags_in;
			default: read_mux = 8'h00;
			endcase
		end
	endfunction

	// The value is captured when the read begins so that the flag clear
	// does not alter what the host sees during the strobe.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			data_out_ff <= 8'h00;
			data_oe_ff <= 1'b0;
		end else begin
			data_oe_ff <= rd_act;
			if (rd_start) begin
				data_out_ff <= read_mux(ia_s);
			end
		end
	end

endmodule // llc_reg_bank
`default_nettype wire

// ===== verilog/llc_setup_seq.v
// Link set-up sequencer of the link control block.
`default_nettype none
`include "llc_link_defines.vh"

module llc_setup_seq (
	input wire core_clk,
	input wire rst_n,
	input wire manual_disconnect,
	input wire link_initiate,
	input wire disconnect_before_setup,
	input wire remote_setup_rcvd,
	input wire ack_rcvd,
	input wire link_lost,
	output reg send_disc_ff,
	output reg send_sabm_ff,
	output reg send_ack_ff,
	output reg link_up_ff,
	output reg [2:0] state_ff
);

	reg [2:0] nxt_state;

	// -----------------------------------------------------------------
	// State register and command strobes
	// -----------------------------------------------------------------
	always @(posedge core_clk) begin
		if (!rst_n) begin
			state_ff <= `LLC_ST_IDLE;
			send_disc_ff <= 1'b0;
			send_sabm_ff <= 1'b0;
			send_ack_ff <= 1'b0;
			link_up_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			send_disc_ff <= (nxt_state == `LLC_ST_SEND_DISC);
			send_sabm_ff <= (nxt_state == `LLC_ST_SEND_SABM);
			send_ack_ff <= (state_ff == `LLC_ST_IDLE) && (nxt_state == `LLC_ST_UP);
			link_up_ff <= (nxt_state == `LLC_ST_UP);
		end
	end

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
		`LLC_ST_IDLE: begin
			if (manual_disconnect) begin
				nxt_state = `LLC_ST_IDLE;
			end else if (link_initiate) begin
				nxt_state = disconnect_before_setup ? `LLC_ST_SEND_DISC : `LLC_ST_SEND_SABM;
			end else if (remote_setup_rcvd) begin
				nxt_state = `LLC_ST_UP;
			end
		end
		`LLC_ST_SEND_DISC: begin
			nxt_state = `LLC_ST_WAIT_DISC;
		end
		`LLC_ST_WAIT_DISC: begin
			if (ack_rcvd) begin
				nxt_state = `LLC_ST_SEND_SABM;
			end
		end
		`LLC_ST_SEND_SABM: begin
			nxt_state = `LLC_ST_WAIT_SABM;
		end
		`LLC_ST_WAIT_SABM: begin
			if (ack_rcvd) begin
				nxt_state = `LLC_ST_UP;
			end
		end
		`LLC_ST_UP: begin
			if (link_lost) begin
				nxt_state = `LLC_ST_IDLE;
			end
		end
		default: begin
			nxt_state = `LLC_ST_IDLE;
		end
		endcase
		if (manual_disconnect) begin
			nxt_state = `LLC_ST_IDLE;
		end
	end

endmodule // llc_setup_seq
`default_nettype wire
